// *** tb/ext_sram_model.sv ***
// Behavioural asynchronous byte-wide memory on the far side of the pins.
`timescale 1ns/1ns
module ext_sram_model
#(
  parameter int ACCESS_NS = 20
)
(
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  pin_data,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  output logic [7:0]       rd_data
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_q = 8'h00;

  always @(posedge we_n) mem[addr] = pin_data;

  // The bus has no pull, so a released bus shows the inverse of the last byte
  // rather than a value the simulator might happen to settle on.
  always @(negedge oe_n)
  begin
    rd_data = ~last_q;
    #ACCESS_NS;
    if (!oe_n)
    begin
      rd_data = mem[addr];
      last_q = rd_data;
    end
  end

  always @(posedge oe_n) rd_data = ~last_q;
endmodule : ext_sram_model

// *** tb/tb_ext_program_memory_interface.sv ***
// Self-checking bench for the external program-memory interface.
`timescale 1ns/1ns
module tb_ext_program_memory_interface
  import ext_mem_pkg::*;
  ;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        core_req = 1'b0, break_select = 1'b0, flash_secure = 1'b0;
  logic [7:0]  core_opcode = 8'h00, core_wdata = 8'h00, flash_rdata = 8'h00;
  logic [15:0] core_addr = 16'h0, data_pointer = 16'h0, flash_addr, ext_addr, bnd;
  logic        core_stall, core_ack, dp_increment, software_break, dbus_oe, oe_n, we_n;
  logic        fl_req, fl_wr;
  logic [7:0]  fl_wd, fw_dat;
  logic [7:0]  core_rdata, dbus_out, mem_out, dbus, we_dat, prev_dout = 8'h00;
  logic [15:0] tgt = 16'h0001, prev_addr = 16'h0, oe_at, we_at, doe_at;
  logic        prev_oe = 1'b1, prev_we = 1'b1, prev_doe = 1'b0, brk, inc;
  int          fail_count = 0, n_tests = 0, stall_c, oe_c, we_c, addr_c, bad_c, w, b, fr_c;

  ext_program_memory_interface dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_req, .core_opcode,
    .core_addr, .data_pointer, .core_wdata, .break_select, .flash_secure, .core_stall,
    .core_ack, .core_rdata, .dp_increment, .software_break, .flash_req(fl_req),
    .flash_write(fl_wr), .flash_addr, .flash_wdata(fl_wd), .flash_rdata, .ext_addr_bus(ext_addr),
    .ext_data_bus_in(dbus), .ext_data_bus_out(dbus_out), .ext_data_bus_oe(dbus_oe),
    .ext_output_enable_n(oe_n), .ext_write_strobe_n(we_n));

  ext_sram_model mem_u (.addr(ext_addr), .pin_data(dbus), .oe_n(oe_n), .we_n(we_n),
    .rd_data(mem_out));

  assign dbus = (dbus_oe === 1'b1) ? dbus_out : mem_out;

  initial forever #25 aclk = ~aclk;

  // The flash answers within the cycle in which its address stands, as the sequencer
  // samples it in that same cycle.
  always @(flash_addr) flash_rdata = flash_addr[7:0] ^ 8'h3c;

  // --------------------------------------------------------------
  // Pin monitor
  // --------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (core_stall === 1'b1) stall_c++;
    if (oe_n === 1'b0) oe_c++;
    if (we_n === 1'b0) we_c++;
    if (ext_addr === tgt) addr_c++;
    if (oe_n === 1'b0 && dbus_oe === 1'b1) bad_c++;
    if (fl_req === 1'b1) fr_c++;
    if (fl_req === 1'b1) fw_dat = (fl_wr === 1'b1) ? fl_wd : 8'h00;
    if (oe_n === 1'b0 && prev_oe) oe_at = prev_addr;
    if (we_n === 1'b0 && prev_we) we_at = prev_addr;
    if (we_n === 1'b0 && prev_we) we_dat = prev_doe ? prev_dout : 8'hxx;
    if (dbus_oe === 1'b1 && !prev_doe) doe_at = prev_addr;
    prev_oe = (oe_n !== 1'b0);
    prev_we = (we_n !== 1'b0);
    prev_doe = (dbus_oe === 1'b1);
    prev_addr = ext_addr;
    prev_dout = dbus_out;
  end

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  task automatic tmo();
    $display("ERROR wait limit expected handshake seen none");
    fail_count++;
    stop_test();
  endtask : tmo

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] rs);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    rs = s_axi_bresp;
    if (n == 40) tmo();
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rs);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    rs = s_axi_rresp;
    if (n == 40) tmo();
  endtask : axi_rd

  task automatic set_cfg(input logic [7:0] v);
    logic [31:0] d;
    logic [1:0]  rs;
    axi_wr(CFG_ADDR, {24'h0, v}, rs);
    axi_rd(CFG_ADDR, d, rs);
    chk("config readback", {24'h0, v}, {24'h0, d[7:0]});
  endtask : set_cfg

  // A read expects the memory byte when external, else the flash pattern.
  task automatic core_op(input logic [7:0] op, input logic [15:0] a, input logic [7:0] d,
                         input bit ext, input int ws);
    int n;
    @(posedge aclk);
    core_req <= 1'b1;
    core_opcode <= op;
    core_addr <= a;
    data_pointer <= a;
    core_wdata <= d;
    {stall_c, oe_c, we_c, addr_c, bad_c, fr_c} = '0;
    tgt = a;
    for (n = 0; n < 100; n++)
    begin
      @(posedge aclk);
      if (core_ack === 1'b1) break;
    end
    core_req <= 1'b0;
    brk = software_break;
    inc = dp_increment;
    if (n == 100) tmo();
    if (ext)
    begin
      chk("stall cycles", 8 + ws, stall_c);
      chk("address cycles", 7 + ws, addr_c);
    end
    chk("oe low", (ext && op != STORE_OPCODE) ? 1 + ws : 0, oe_c);
    chk("we low", (ext && op == STORE_OPCODE) ? 1 + ws : 0, we_c);
    chk("oe while driving", 0, bad_c);
    chk("flash requests", (!ext && !(op == STORE_OPCODE && break_select)) ? 1 : 0, fr_c);
    if (!ext && op == STORE_OPCODE && !break_select)
      chk("flash store", d, fw_dat);
    chk("break", op == STORE_OPCODE && break_select, brk);
    chk("pointer step", op == STORE_OPCODE && !break_select, inc);
    if (ext && op == STORE_OPCODE)
    begin
      chk("data addr", a, doe_at);
      chk("strobe addr", a, we_at);
      chk("strobe data", d, we_dat);
    end
    if (op != STORE_OPCODE)
      chk("read byte", ext ? d : a[7:0] ^ 8'h3c, core_rdata);
    if (ext && op != STORE_OPCODE)
      chk("oe addr", a, oe_at);
  endtask : core_op

  // --------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(CFG_ADDR, rd, r);
    chk("config reset", {24'h0, CFG_RESET}, rd);
    core_op(8'h00, 16'hfff0, 8'h00, 0, 0);
    axi_rd(12'h100, rd, r);
    chk("unmapped read", RESP_DECERR, r);
    axi_wr(12'h100, 32'h0, r);
    chk("unmapped write", RESP_DECERR, r);
    for (w = 0; w < 4; w += 3)
    begin
      set_cfg({w[3:0], 4'h0});
      core_op(STORE_OPCODE, 16'he123, 8'(8'h5a + w), 1, w);
      core_op(8'h00, 16'he123, 8'(8'h5a + w), 1, w);
    end
    for (b = 0; b < 8; b++)
    begin
      bnd = (b == 7) ? 16'h0011 : 16'he000 - 16'(b) * 16'h2000;
      set_cfg({4'h1, b[2:0], 1'b0});
      if (b < 7) core_op(8'h00, bnd - 16'h1, 8'h00, 0, 1);
      core_op(STORE_OPCODE, bnd, 8'(b), 1, 1);
      core_op(8'h00, bnd, 8'(b), 1, 1);
    end
    set_cfg(8'h1f);
    core_op(8'h00, 16'h0011, 8'h00, 0, 1);
    core_op(STORE_OPCODE, 16'h0011, 8'h66, 0, 1);
    set_cfg(8'h1e);
    break_select <= 1'b1;
    core_op(STORE_OPCODE, 16'h2222, 8'h77, 0, 1);
    break_select <= 1'b0;
    flash_secure <= 1'b1;
    axi_wr(CFG_ADDR, 32'h0, r);
    axi_rd(CFG_ADDR, rd, r);
    chk("secure all-onchip", 1, rd[0]);
    core_op(8'h00, 16'h0011, 8'h00, 0, 1);
    stop_test();
  end
endmodule : tb_ext_program_memory_interface

// *** verilog/ext_mem_pkg.sv ***
// Package with register map, field layout and bus timing constants.
package ext_mem_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0]  CFG_INDEX      = 8'hc5;
  localparam logic [11:0] CFG_ADDR       = {2'h0, CFG_INDEX, 2'h0};
  localparam logic [11:0] STATUS_ADDR    = 12'h318;
  localparam logic [7:0]  CFG_RESET      = 8'h01;

  // ---------------------------------------------------------------
  // Field positions of external_memory_config
  // ---------------------------------------------------------------
  localparam int          WAIT_LSB       = 4;
  localparam int          WAIT_MSB       = 7;
  localparam int          BANK_LSB       = 1;
  localparam int          BANK_MSB       = 3;
  localparam int          ALL_ONCHIP_BIT = 0;

  // ---------------------------------------------------------------
  // Status register bits
  // ---------------------------------------------------------------
  localparam int          ST_BUSY_BIT    = 0;
  localparam int          ST_SECURE_BIT  = 1;
  localparam int          ST_EXT_BIT     = 2;
  localparam int          ST_DATA_LSB    = 8;

  // ---------------------------------------------------------------
  // Core side and bus timing, in core clock cycles
  // ---------------------------------------------------------------
  localparam logic [7:0]  STORE_OPCODE   = 8'ha5;
  localparam logic [4:0]  ADDR_CYCLES    = 5'h04;
  localparam logic [4:0]  HOLD_CYCLES    = 5'h02;
  localparam logic [4:0]  MIN_CYCLE      = 5'h07;
  localparam logic [4:0]  MIN_ACCESS     = 5'h05;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_DECERR    = 2'h3;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_FLASH  = 6'h02,
    ST_ADDR   = 6'h04,
    ST_STROBE = 6'h08,
    ST_HOLD   = 6'h10,
    ST_DONE   = 6'h20
  } bus_state_t;

endpackage : ext_mem_pkg

// *** verilog/ext_program_memory_interface.sv ***
// External program-memory interface with its configuration registers.
// How it works
// RULE_01 - Sixteen address lines, eight data lines, write strobe and output enable.
// RULE_02 - After reset all program accesses go to flash, no external cycles.
// RULE_03 - Secure flash keeps everything on-chip; no external cycle ever starts.
// RULE_04 - In secure mode the all-on-chip bit reads one; writes cannot change it.
// RULE_05 - Bits 7:4 give wait states, same count for reads and writes.
// RULE_06 - Output enable stays low one cycle plus the wait count.
// RULE_07 - Write strobe stays low one cycle plus the wait count.
// RULE_08 - Bits 3:1 move the external boundary down from 0xE000 by 0x2000 per code.
// RULE_09 - Bit 0 set sends all to flash; clear lets the bank field decide.
// RULE_10 - On reads the address comes out before output enable falls.
// RULE_11 - Read data is taken as output enable rises.
// RULE_12 - On writes address first, then data, then the write strobe.
// RULE_13 - The memory stores write data at the rising write strobe.
// RULE_14 - Every external cycle lasts seven cycles plus one per wait state.
// RULE_15 - Memory gets at least five cycles of access time.
// RULE_16 - No ready input; only the wait count sets cycle length.
// RULE_17 - Reads are code moves; stores use the data pointer, then increment it.
// RULE_18 - Store opcode stores only when break select is clear, else breaks.
// RULE_19 - Address, data and strobes are pins shared with general ports.
// RULE_20 - Strobes idle high; data bus driven only while writing.
// RULE_21 - The core stalls until the whole cycle ends, then gets data or ack.
`timescale 1ns/1ns
module ext_program_memory_interface
  import ext_mem_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite register port
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Core request port
  input  wire logic        core_req,
  input  wire logic [7:0]  core_opcode,
  input  wire logic [15:0] core_addr,
  input  wire logic [15:0] data_pointer,
  input  wire logic [7:0]  core_wdata,
  input  wire logic        break_select,
  input  wire logic        flash_secure,
  output logic             core_stall,
  output logic             core_ack,
  output logic [7:0]       core_rdata,
  output logic             dp_increment,
  output logic             software_break,
  // On-chip flash port
  output logic             flash_req,
  output logic             flash_write,
  output logic [15:0]      flash_addr,
  output logic [7:0]       flash_wdata,
  input  wire logic [7:0]  flash_rdata,
  // External memory pins
  output logic [15:0]      ext_addr_bus,
  input  wire logic [7:0]  ext_data_bus_in,
  output logic [7:0]       ext_data_bus_out,
  output logic             ext_data_bus_oe,
  output logic             ext_output_enable_n,
  output logic             ext_write_strobe_n
);

  // ---------------------------------------------------------------
  // Configuration register and AXI4-Lite slave
  // ---------------------------------------------------------------
  logic [7:0]  cfg_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;
  bus_state_t  state_q;
  bus_state_t  state_d;
  logic [7:0]  rd_byte_q;

  wire         wr_take    = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  wire         rd_take    = s_axi_arvalid && !rvalid_q;
  wire         wr_cfg     = wr_take && (s_axi_awaddr == CFG_ADDR) && s_axi_wstrb[0];
  wire         wr_hit     = (s_axi_awaddr == CFG_ADDR) || (s_axi_awaddr == STATUS_ADDR);
  wire         rd_cfg     = (s_axi_araddr == CFG_ADDR);
  wire         rd_status  = (s_axi_araddr == STATUS_ADDR);
  wire [31:0]  status_val = {16'h0000, rd_byte_q, 5'h00,
                             (state_q == ST_ADDR) || (state_q == ST_STROBE)
                             || (state_q == ST_HOLD),
                             flash_secure, state_q != ST_IDLE};
  wire [31:0]  rd_val     = rd_cfg ? {24'h000000, cfg_q} : (rd_status ? status_val : 32'h0);

  // RULE_04 - secure pins bit zero
  wire [7:0]   cfg_wr_val = {s_axi_wdata[7:1], s_axi_wdata[0] | flash_secure};

  assign s_axi_awready = wr_take;
  assign s_axi_wready  = wr_take;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = rd_take;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  // RULE_02 - reset value is flash only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cfg_q <= CFG_RESET;
    else if (wr_cfg)
      cfg_q <= cfg_wr_val;
    else if (flash_secure)
      cfg_q[ALL_ONCHIP_BIT] <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end
    else if (wr_take)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? RESP_OKAY : RESP_DECERR;
    end
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= 32'h0;
    end
    else if (rd_take)
    begin
      rvalid_q <= 1'b1;
      rresp_q  <= (rd_cfg || rd_status) ? RESP_OKAY : RESP_DECERR;
      rdata_q  <= rd_val;
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Address decode and request classification
  // ---------------------------------------------------------------
  wire [3:0]  wait_cfg   = cfg_q[WAIT_MSB:WAIT_LSB];
  wire [2:0]  bank_cfg   = cfg_q[BANK_MSB:BANK_LSB];
  wire        is_store   = (core_opcode == STORE_OPCODE);
  // RULE_18 - break select turns the store into a break
  wire        is_break   = is_store && break_select;
  // RULE_17 - stores address through the data pointer
  wire [15:0] req_addr   = is_store ? data_pointer : core_addr;
  // RULE_08 - boundary falls by one 8 KB step per code
  wire        bank_ext   = (req_addr[15:13] >= (3'h7 - bank_cfg));
  // RULE_09 - all-on-chip bit overrides bank field
  // RULE_03 - secure flash never goes external
  wire        ext_hit    = !flash_secure && !cfg_q[ALL_ONCHIP_BIT] && bank_ext;
  wire        req_new    = core_req && (state_q == ST_IDLE) && !core_ack;

  // ---------------------------------------------------------------
  // Bus sequencer
  // ---------------------------------------------------------------
  phase_count_if phase ();

  phase_counter u_phase_counter
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cnt     (phase)
  );

  logic [15:0] addr_q;
  logic [7:0]  wdata_q;
  logic        write_q;
  logic [3:0]  wait_q;
  logic        ack_q;
  logic        incr_q;
  logic        break_q;
  logic [7:0]  core_rdata_q;
  logic        flash_req_q;
  logic        first_addr_q;
  logic [7:0]  data_meta_q;
  logic [7:0]  data_sync_q;

  // RULE_14 - four address, two hold
  // RULE_15 - access spans address and strobe
  // RULE_16 - strobe phase length comes only from the wait count
  always_comb
  begin
    state_d      = state_q;
    phase.load   = 1'b0;
    phase.value  = 5'h00;
    case (state_q)
      ST_IDLE:
      begin
        if (req_new && !is_break)
        begin
          if (ext_hit)
          begin
            state_d     = ST_ADDR;
            phase.load  = 1'b1;
            phase.value = ADDR_CYCLES - 5'h01;
          end
          else
            state_d = ST_FLASH;
        end
      end
      ST_FLASH:
        state_d = ST_DONE;
      ST_ADDR:
      begin
        if (phase.zero)
        begin
          state_d     = ST_STROBE;
          phase.load  = 1'b1;
          phase.value = {1'b0, wait_q};
        end
      end
      ST_STROBE:
      begin
        if (phase.zero)
        begin
          state_d     = ST_HOLD;
          phase.load  = 1'b1;
          phase.value = HOLD_CYCLES - 5'h01;
        end
      end
      ST_HOLD:
      begin
        if (phase.zero)
          state_d = ST_DONE;
      end
      ST_DONE:
        state_d = ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // RULE_05 - one wait count for both directions, frozen per cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      addr_q  <= 16'h0000;
      wdata_q <= 8'h00;
      write_q <= 1'b0;
      wait_q  <= 4'h0;
    end
    else if (req_new && !is_break)
    begin
      addr_q  <= req_addr;
      wdata_q <= core_wdata;
      write_q <= is_store;
      wait_q  <= wait_cfg;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      first_addr_q <= 1'b0;
    else
      first_addr_q <= req_new && !is_break && ext_hit;
  end

  // The first data flop sees the pin, the second sees the first; the capture reads the second.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      data_meta_q <= 8'h00;
      data_sync_q <= 8'h00;
    end
    else
    begin
      data_meta_q <= ext_data_bus_in;
      data_sync_q <= data_meta_q;
    end
  end

  // RULE_11 - synced copy equals the pin at the rising output enable
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      core_rdata_q <= 8'h00;
    else if (state_q == ST_HOLD && phase.zero && !write_q)
      core_rdata_q <= data_sync_q;
    else if (state_q == ST_FLASH && !write_q)
      core_rdata_q <= flash_rdata;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rd_byte_q <= 8'h00;
    else if (state_q == ST_DONE && !write_q)
      rd_byte_q <= core_rdata_q;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flash_req_q <= 1'b0;
    else
      flash_req_q <= req_new && !is_break && !ext_hit;
  end

  // RULE_21 - acknowledge only after the whole cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ack_q   <= 1'b0;
      incr_q  <= 1'b0;
      break_q <= 1'b0;
    end
    else
    begin
      ack_q   <= (state_d == ST_DONE) || (req_new && is_break);
      incr_q  <= (state_d == ST_DONE) && write_q;
      break_q <= req_new && is_break;
    end
  end

  assign core_ack       = ack_q;
  assign core_stall     = core_req && !ack_q;
  assign core_rdata     = core_rdata_q;
  assign dp_increment   = incr_q;
  assign software_break = break_q;
  assign flash_req      = flash_req_q;
  assign flash_write    = flash_req_q && write_q;
  assign flash_addr     = addr_q;
  assign flash_wdata    = wdata_q;

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  wire ext_active = (state_q == ST_ADDR) || (state_q == ST_STROBE) || (state_q == ST_HOLD);

  // RULE_01 - address bus driven from the cycle register
  // RULE_19 - pins handed to port mux through these outputs
  assign ext_addr_bus        = ext_active ? addr_q : 16'h0000;
  // RULE_10 - output enable only after the address phase
  // RULE_06 - low for one plus wait cycles
  assign ext_output_enable_n = !((state_q == ST_STROBE) && !write_q);
  // RULE_07 - low for one plus wait cycles
  assign ext_write_strobe_n  = !((state_q == ST_STROBE) && write_q);
  // RULE_12 - data follows the first address cycle
  // RULE_13 - data held past the rising write strobe
  // RULE_20 - bus released except while writing
  assign ext_data_bus_oe     = ext_active && write_q && !first_addr_q;
  assign ext_data_bus_out    = wdata_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [4:0] low_len_q;
  logic [4:0] cyc_len_q;
  logic [4:0] acc_len_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      low_len_q <= 5'h00;
      cyc_len_q <= 5'h00;
      acc_len_q <= 5'h00;
    end
    else
    begin
      low_len_q <= (state_q == ST_STROBE) ? low_len_q + 5'h01 : 5'h00;
      cyc_len_q <= ext_active ? cyc_len_q + 5'h01 : 5'h00;
      acc_len_q <= (ext_active && state_q != ST_HOLD) ? acc_len_q + 5'h01 : 5'h00;
    end
  end

  property p_strobes_exclusive;
    @(posedge aclk) disable iff (!aresetn)
    !(!ext_output_enable_n && !ext_write_strobe_n);
  endproperty
  a_strobes_exclusive: assert property (p_strobes_exclusive) // RULE_20
    else $error("both strobes low");

  property p_secure_no_ext;
    @(posedge aclk) disable iff (!aresetn)
    (flash_secure && state_q == ST_IDLE) |-> ##1 !(state_q == ST_ADDR);
  endproperty
  a_secure_no_ext: assert property (p_secure_no_ext) // RULE_03
    else $error("external cycle started in secure mode");

  property p_secure_bit;
    @(posedge aclk) disable iff (!aresetn)
    flash_secure |=> cfg_q[ALL_ONCHIP_BIT];
  endproperty
  a_secure_bit: assert property (p_secure_bit) // RULE_04
    else $error("all-on-chip bit cleared in secure mode");

  property p_read_strobe_len;
    @(posedge aclk) disable iff (!aresetn)
    $rose(ext_output_enable_n) |-> (low_len_q == {1'b0, wait_q} + 5'h01);
  endproperty
  a_read_strobe_len: assert property (p_read_strobe_len) // RULE_06
    else $error("output enable width wrong");

  property p_write_strobe_len;
    @(posedge aclk) disable iff (!aresetn)
    $rose(ext_write_strobe_n) |-> (low_len_q == {1'b0, wait_q} + 5'h01);
  endproperty
  a_write_strobe_len: assert property (p_write_strobe_len) // RULE_07
    else $error("write strobe width wrong");

  property p_addr_before_oe;
    @(posedge aclk) disable iff (!aresetn)
    $fell(ext_output_enable_n) |-> $past(ext_active) && $stable(ext_addr_bus);
  endproperty
  a_addr_before_oe: assert property (p_addr_before_oe) // RULE_10
    else $error("output enable before address");

  property p_data_before_we;
    @(posedge aclk) disable iff (!aresetn)
    $fell(ext_write_strobe_n) |-> $past(ext_data_bus_oe) && ext_data_bus_oe;
  endproperty
  a_data_before_we: assert property (p_data_before_we) // RULE_12
    else $error("write strobe before data");

  property p_cycle_len;
    @(posedge aclk) disable iff (!aresetn)
    (state_q == ST_HOLD && phase.zero) |->
      (cyc_len_q + 5'h01 == MIN_CYCLE + {1'b0, wait_q});
  endproperty
  a_cycle_len: assert property (p_cycle_len) // RULE_14
    else $error("external cycle length wrong");

  property p_access_time;
    @(posedge aclk) disable iff (!aresetn)
    $rose(ext_output_enable_n) |-> (acc_len_q >= MIN_ACCESS);
  endproperty
  a_access_time: assert property (p_access_time) // RULE_15
    else $error("access time too short");

  property p_break;
    @(posedge aclk) disable iff (!aresetn)
    (req_new && is_store && break_select) |=> software_break && core_ack && !dp_increment;
  endproperty
  a_break: assert property (p_break) // RULE_18
    else $error("break opcode not taken as break");

  property p_reset_flash;
    @(posedge aclk)
    !aresetn |=> cfg_q == CFG_RESET && state_q == ST_IDLE;
  endproperty
  a_reset_flash: assert property (p_reset_flash) // RULE_02
    else $error("reset state not flash only");

endmodule : ext_program_memory_interface

// *** verilog/phase_count_if.sv ***
// Interface between the bus sequencer and its phase counter.
`timescale 1ns/1ns
interface phase_count_if;
  logic       load;
  logic [4:0] value;
  logic       zero;
  modport owner (output load, output value, input zero);
  modport counter (input load, input value, output zero);
endinterface : phase_count_if

// *** verilog/phase_counter.sv ***
// Loadable down counter that times each phase of an external cycle.
`timescale 1ns/1ns
module phase_counter
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  phase_count_if.counter    cnt
);
  logic [4:0] count_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_q <= 5'h00;
    else if (cnt.load)
      count_q <= cnt.value;
    else if (count_q != 5'h00)
      count_q <= count_q - 5'h01;
  end

  assign cnt.zero = (count_q == 5'h00);
endmodule : phase_counter
